// ===== hdl/rac_pkg.sv
package rac_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_REF_CTL   = 8'h00;
  localparam logic [7:0] ADDR_CONV_CTL  = 8'h04;
  localparam logic [7:0] ADDR_RES_HI    = 8'h08;
  localparam logic [7:0] ADDR_RES_LO    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;

  // ----------------------------------------
  // Reference control field layout
  // ----------------------------------------
  localparam int REF_EN_BIT     = 7;
  localparam int REF_RDY_BIT    = 6;
  localparam int TEMP_EN_BIT    = 5;
  localparam int TEMP_RNG_BIT   = 4;
  localparam int CMP_GAIN_LSB   = 2;
  localparam int CONV_GAIN_LSB  = 0;
  localparam logic [7:0] REF_CTL_RESET = 8'h00;

  // ----------------------------------------
  // Converter control and interrupt layout
  // ----------------------------------------
  localparam int GO_BIT       = 0;
  localparam int CHAN_LSB     = 1;
  localparam int CHAN_W       = 3;
  localparam int REF_EXT_BIT  = 4;
  localparam int DONE_BIT     = 0;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic       FLAG_RESET = 1'h0;
  localparam logic [7:0] RES_RESET  = 8'h00;

  // ----------------------------------------
  // Result and gain encodings
  // ----------------------------------------
  localparam int RES_W = 10;
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_1X  = 2'h1;
  localparam logic [1:0] GAIN_2X  = 2'h2;
  localparam logic [1:0] GAIN_4X  = 2'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SAMPLE_TIME_NS = 200;
  localparam int BIT_TIME_NS    = 40;
  localparam int SAMPLE_CYCLES  = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CYCLES     = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Converter sequencer states
  typedef enum logic [2:0] {
    RAC_IDLE   = 3'b001,
    RAC_SAMPLE = 3'b010,
    RAC_CONV   = 3'b100
  } rac_sar_state_e;

endpackage : rac_pkg

// ===== hdl/rac_sar.sv
`timescale 1ns/1ns
module rac_sar
  import rac_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             start,
  input  wire logic             cmp_hi,
  // Converter front end
  output logic                  sample_q,
  output logic [RES_W-1:0]      dac_q,
  // Status
  output logic                  busy_q,
  output logic                  done_q,
  output logic [RES_W-1:0]      result_q
);

  localparam int CONV_LAT = SAMPLE_CYCLES + RES_W * BIT_CYCLES + 1;

  rac_sar_state_e state_q;
  logic [7:0]     cnt_q;
  logic [3:0]     idx_q;

  // ----------------------------------------
  // Sample, then one trial per result bit
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= RAC_IDLE;
      cnt_q    <= 8'h00;
      idx_q    <= 4'h0;
      sample_q <= 1'b0;
      dac_q    <= '0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      result_q <= '0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        RAC_IDLE: begin
          if (start) begin
            state_q  <= RAC_SAMPLE;
            sample_q <= 1'b1;
            busy_q   <= 1'b1;
            cnt_q    <= 8'(SAMPLE_CYCLES - 1);
          end
        end
        RAC_SAMPLE: begin
          if (cnt_q == 8'h00) begin
            state_q  <= RAC_CONV;
            sample_q <= 1'b0;
            idx_q    <= 4'(RES_W - 1);
            dac_q    <= {1'b1, {(RES_W-1){1'b0}}};
            cnt_q    <= 8'(BIT_CYCLES - 1);
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        RAC_CONV: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (idx_q == 4'h0) begin
            // Last trial decides bit 0 and ends the conversion
            result_q <= {dac_q[RES_W-1:1], cmp_hi};
            dac_q[0] <= cmp_hi;
            done_q   <= 1'b1;
            busy_q   <= 1'b0;
            state_q  <= RAC_IDLE;
          end else begin
            dac_q[idx_q]        <= cmp_hi;
            dac_q[idx_q - 4'h1] <= 1'b1;
            idx_q               <= idx_q - 4'h1;
            cnt_q               <= 8'(BIT_CYCLES - 1);
          end
        end
        default: begin
          state_q <= RAC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence conv_start_s;
    start && state_q == RAC_IDLE;
  endsequence

  sample_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_start_s |=> sample_q [*8])
    else $error("Sample phase not held after start");

  conv_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    conv_start_s |-> ##CONV_LAT done_q)
    else $error("Conversion did not finish on time");

endmodule : rac_sar

// ===== hdl/rac_top.sv
// What this block does
// - Reference ready flag always reads one, regardless of the enable bit.
// - Converter turns the selected input into a 10-bit binary value.
// - Inputs pass a channel multiplexer into one shared sample-and-hold stage.
// - Each finished conversion writes the high and low result byte pair.
// - Software picks internal fixed reference or external reference.
// - Conversion complete raises an interrupt request.
// - Conversion complete interrupt can wake the device from sleep.
`timescale 1ns/1ns
module rac_top
  import rac_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Reference buffers
  output logic                   ref_enable,
  output logic                   temp_indicator_enable,
  output logic                   temp_indicator_range,
  output logic [2:0]             comparator_gain_sel,
  output logic [2:0]             converter_gain_sel,
  // Converter front end
  input  wire logic              cmp_in,
  output logic [CHAN_W-1:0]      chan_sel,
  output logic                   ref_external,
  output logic                   sample_hold,
  output logic [RES_W-1:0]       dac_code,
  // Power and interrupt
  input  wire logic              sleep_mode,
  output logic                   irq,
  output logic                   wake_req
);

  // ----------------------------------------
  // Reset release and comparator sync
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_sync_n;
  logic cmp_meta_q;
  logic cmp_sync_q;

  // Asynchronous assert, synchronous release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // Comparator level comes from the analog side
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_in;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  logic        wait_q;
  logic        rd_acc;
  logic        wr_acc;
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;
  logic [7:0]  wbyte;

  assign rd_acc = avs_read && !wait_q;
  assign wr_acc = avs_write && !wait_q && avs_byteenable[0];
  assign wbyte  = avs_writedata[7:0];

  // One wait cycle per request, then one ready cycle
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]        ref_ctl_q;
  logic [CHAN_W-1:0] chan_q;
  logic              ref_ext_sel_q;
  logic              start_q;
  logic [7:0]        res_hi_q;
  logic [7:0]        res_lo_q;
  logic              stat_q;
  logic              mask_q;
  logic              sar_busy;
  logic              sar_done;
  logic [RES_W-1:0]  sar_result;

  // Reference control; ready bit is not stored
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_ctl_q <= REF_CTL_RESET;
    end else if (wr_acc && avs_address == ADDR_REF_CTL) begin
      ref_ctl_q <= wbyte & ~(8'h01 << REF_RDY_BIT);
    end
  end

  // Converter control and start pulse
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chan_q        <= CHAN_RESET;
      ref_ext_sel_q <= FLAG_RESET;
      start_q       <= FLAG_RESET;
    end else begin
      start_q <= 1'b0;
      if (wr_acc && avs_address == ADDR_CONV_CTL) begin
        chan_q        <= wbyte[CHAN_LSB +: CHAN_W];
        ref_ext_sel_q <= wbyte[REF_EXT_BIT];
        start_q       <= wbyte[GO_BIT] && !sar_busy && !start_q;
      end
    end
  end

  // Result pair; completion wins over a software write
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      res_hi_q <= RES_RESET;
      res_lo_q <= RES_RESET;
    end else if (sar_done) begin
      res_hi_q <= sar_result[RES_W-1:2];
      res_lo_q <= {sar_result[1:0], 6'h00};
    end else if (wr_acc && avs_address == ADDR_RES_HI) begin
      res_hi_q <= wbyte;
    end else if (wr_acc && avs_address == ADDR_RES_LO) begin
      res_lo_q <= wbyte;
    end
  end

  // Sticky done flag; set beats read clear
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stat_q <= FLAG_RESET;
    end else if (sar_done) begin
      stat_q <= 1'b1;
    end else if (rd_acc && avs_address == ADDR_IRQ_STAT) begin
      stat_q <= 1'b0;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_q <= FLAG_RESET;
    end else if (wr_acc && avs_address == ADDR_IRQ_MASK) begin
      mask_q <= wbyte[DONE_BIT];
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      ADDR_REF_CTL:  rd_mux[7:0] = ref_ctl_q | (8'h01 << REF_RDY_BIT);
      ADDR_CONV_CTL: begin
        rd_mux[GO_BIT]                = sar_busy;
        rd_mux[CHAN_LSB +: CHAN_W]    = chan_q;
        rd_mux[REF_EXT_BIT]           = ref_ext_sel_q;
      end
      ADDR_RES_HI:   rd_mux[7:0] = res_hi_q;
      ADDR_RES_LO:   rd_mux[7:0] = res_lo_q;
      ADDR_IRQ_STAT: rd_mux[DONE_BIT] = stat_q;
      ADDR_IRQ_MASK: rd_mux[DONE_BIT] = mask_q;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Data captured as waitrequest drops
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------
  // Buffer gain decode, one per path
  // ----------------------------------------
  logic [2:0] gain_q [2];

  for (genvar p = 0; p < 2; p++) begin : g_gain
    localparam int LSB = (p == 0) ? CONV_GAIN_LSB : CMP_GAIN_LSB;
    always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        gain_q[p] <= 3'h0;
      end else begin
        case (ref_ctl_q[LSB +: 2])
          GAIN_1X: gain_q[p] <= 3'h1;
          GAIN_2X: gain_q[p] <= 3'h2;
          GAIN_4X: gain_q[p] <= 3'h4;
          default: gain_q[p] <= 3'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Front end routing
  // ----------------------------------------
  logic [CHAN_W-1:0] chan_sel_q;
  logic              ref_ext_q;
  logic              irq_q;
  logic              wake_q;

  // Channel and reference fixed for a whole conversion
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chan_sel_q <= CHAN_RESET;
      ref_ext_q  <= FLAG_RESET;
    end else if (start_q) begin
      chan_sel_q <= chan_q;
      ref_ext_q  <= ref_ext_sel_q;
    end
  end

  // Interrupt and wake levels
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= stat_q && mask_q;
      wake_q <= stat_q && mask_q && sleep_mode;
    end
  end

  rac_sar u_sar (
    .clk      (clk),
    .rst_n    (rst_sync_n),
    .start    (start_q),
    .cmp_hi   (cmp_sync_q),
    .sample_q (sample_hold),
    .dac_q    (dac_code),
    .busy_q   (sar_busy),
    .done_q   (sar_done),
    .result_q (sar_result)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata          = rdata_q;
  assign avs_waitrequest       = wait_q;
  assign ref_enable            = ref_ctl_q[REF_EN_BIT];
  assign temp_indicator_enable = ref_ctl_q[TEMP_EN_BIT];
  assign temp_indicator_range  = ref_ctl_q[TEMP_RNG_BIT];
  assign converter_gain_sel    = gain_q[0];
  assign comparator_gain_sel   = gain_q[1];
  assign chan_sel              = chan_sel_q;
  assign ref_external          = ref_ext_q;
  assign irq                   = irq_q;
  assign wake_req              = wake_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence done_unmasked_s;
    sar_done && mask_q ##1 mask_q;
  endsequence

  ready_reads_one_a: assert property (
    avs_read && !wait_q && avs_address == ADDR_REF_CTL |-> avs_readdata[REF_RDY_BIT])
    else $error("Reference ready flag read as zero");

  result_pair_a: assert property (
    sar_done |=> res_hi_q == $past(sar_result[RES_W-1:2])
                 && res_lo_q[7:6] == $past(sar_result[1:0]))
    else $error("Result pair not stored on completion");

  done_irq_a: assert property (
    done_unmasked_s |-> ##1 irq)
    else $error("Completion did not raise interrupt");

  sleep_wake_a: assert property (
    done_unmasked_s ##0 sleep_mode |-> ##1 wake_req)
    else $error("Completion did not wake from sleep");

  conv_gain_a: assert property (
    ##1 converter_gain_sel == (($past(ref_ctl_q[CONV_GAIN_LSB +: 2]) == GAIN_OFF) ? 3'h0
        : 3'(3'h1 << ($past(ref_ctl_q[CONV_GAIN_LSB +: 2]) - 2'h1))))
    else $error("Converter gain decode wrong");

  cmp_gain_a: assert property (
    ##1 comparator_gain_sel == (($past(ref_ctl_q[CMP_GAIN_LSB +: 2]) == GAIN_OFF) ? 3'h0
        : 3'(3'h1 << ($past(ref_ctl_q[CMP_GAIN_LSB +: 2]) - 2'h1))))
    else $error("Comparator gain decode wrong");

  chan_steady_a: assert property (
    sar_busy && $past(sar_busy) |-> $stable(chan_sel) && $stable(ref_external))
    else $error("Channel or reference moved mid conversion");

  ref_select_a: assert property (
    start_q |=> ref_external == $past(ref_ext_sel_q) && chan_sel == $past(chan_q))
    else $error("Reference choice not applied at start");

endmodule : rac_top

// ===== bench/rac_analog_model.sv
`timescale 1ns/1ns
module rac_analog_model
  import rac_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Converter front end
  input  wire logic [CHAN_W-1:0] chan_sel,
  input  wire logic             ref_external,
  input  wire logic             sample_hold,
  input  wire logic [RES_W-1:0] dac_code,
  output logic                  cmp_in
);
  // ----------------------------------------
  // Analog side
  // ----------------------------------------
  logic [RES_W-1:0] held_q;

  // Input level per channel, bitwise inverted when the external reference is chosen
  function automatic logic [RES_W-1:0] level(input logic [CHAN_W-1:0] ch, input logic ext);
    logic [RES_W-1:0] v;
    v = 10'h0A5 + 10'h071 * ch;
    return ext ? ~v : v;
  endfunction : level

  // Shared sample-and-hold tracks the selected input while sampling
  always_ff @(posedge clk) begin
    if (sample_hold) held_q <= level(chan_sel, ref_external);
  end

  // Comparator: high while held level is at or above the trial code
  always_ff @(posedge clk) begin
    cmp_in <= (held_q >= dac_code);
  end
endmodule : rac_analog_model

// ===== bench/rac_top_tb_top.sv
`timescale 1ns/1ns
module rac_top_tb_top
  import rac_pkg::*;
();
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic             clk, rst_n, avs_read, avs_write, sleep_mode, cmp_in;
  logic [7:0]       avs_address;
  logic [3:0]       avs_byteenable;
  logic [31:0]      avs_writedata, avs_readdata, rd;
  logic             avs_waitrequest, ref_enable, temp_indicator_enable;
  logic             temp_indicator_range, ref_external, sample_hold, irq, wake_req;
  logic [2:0]       comparator_gain_sel, converter_gain_sel;
  logic [CHAN_W-1:0] chan_sel;
  logic [RES_W-1:0] dac_code;
  int               failures, n_checks;

  rac_top dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ref_enable(ref_enable),
    .temp_indicator_enable(temp_indicator_enable), .temp_indicator_range(temp_indicator_range),
    .comparator_gain_sel(comparator_gain_sel), .converter_gain_sel(converter_gain_sel),
    .cmp_in(cmp_in), .chan_sel(chan_sel), .ref_external(ref_external),
    .sample_hold(sample_hold), .dac_code(dac_code), .sleep_mode(sleep_mode), .irq(irq),
    .wake_req(wake_req));

  rac_analog_model far (.clk(clk), .chan_sel(chan_sel), .ref_external(ref_external),
    .sample_hold(sample_hold), .dac_code(dac_code), .cmp_in(cmp_in));

  // Clock
  always #5 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask : chk

  // Avalon read: hold until waitrequest sampled low
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  // Avalon write: hold until waitrequest sampled low
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus_rd(a, rd);
    chk(nm, exp, rd);
  endtask : rd_chk

  function automatic logic pick(input int sel);
    return (sel == 0) ? irq : (sel == 1) ? wake_req : sample_hold;
  endfunction : pick

  // Bounded wait for a level on an output
  task automatic wait_for(input int sel, input logic lvl);
    for (int i = 0; i < 300 && pick(sel) !== lvl; i++) @(posedge clk);
  endtask : wait_for

  function automatic logic [2:0] onehot(input logic [1:0] g);
    return (g == 2'h0) ? 3'h0 : (3'h1 << (g - 2'h1));
  endfunction : onehot

  // Start a conversion and check the latched front-end selection
  task automatic convert(input logic [2:0] ch, input logic ext);
    bus_wr(ADDR_CONV_CTL, {27'h0, ext, ch, 1'b1}, 4'hF);
    wait_for(2, 1'b1);
    chk("sample_hold", 32'h1, {31'h0, sample_hold});
    chk("chan_sel", {29'h0, ch}, {29'h0, chan_sel});
    chk("ref_external", {31'h0, ext}, {31'h0, ref_external});
    wait_for(2, 1'b0);
    chk("dac_first_trial", {22'h0, 1'b1, 9'h000}, {22'h0, dac_code});
  endtask : convert

  // Expected result pair, left justified
  task automatic res_chk(input logic [2:0] ch, input logic ext);
    logic [9:0] v;
    v = 10'h0A5 + 10'h071 * ch;
    if (ext) v = ~v;
    rd_chk("result_high", ADDR_RES_HI, {24'h0, v[9:2]});
    rd_chk("result_low", ADDR_RES_LO, {24'h0, v[1:0], 6'h00});
  endtask : res_chk

  task automatic close_out();
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [2:0]  chs [3];
    logic        exts [3];
    chs = '{3'h0, 3'h5, 3'h7};
    exts = '{1'b0, 1'b1, 1'b0};
    clk = 1'b0; rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; sleep_mode = 1'b0;
    avs_address = 8'h00; avs_byteenable = 4'hF; avs_writedata = 32'h0;
    failures = 0; n_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("ref_ctl_reset", ADDR_REF_CTL, 32'h40);
    rd_chk("unmapped", 8'h18, 32'h0);
    // Every gain code on both paths, decoded apart
    for (int g = 0; g < 4; g++) begin
      d = {24'h0, 2'h3, g[0], g[1], g[1:0], 2'h3 - g[1:0]};
      bus_wr(ADDR_REF_CTL, d, 4'hF);
      rd_chk("ref_ctl", ADDR_REF_CTL, d);
      chk("cmp_gain", {29'h0, onehot(g[1:0])}, {29'h0, comparator_gain_sel});
      chk("conv_gain", {29'h0, onehot(2'h3 - g[1:0])}, {29'h0, converter_gain_sel});
      chk("ref_pins", {29'h0, 1'b1, g[0], g[1]},
          {29'h0, ref_enable, temp_indicator_enable, temp_indicator_range});
    end
    bus_wr(ADDR_REF_CTL, 32'h00, 4'hE);
    rd_chk("byte_disabled", ADDR_REF_CTL, 32'hFC);
    bus_wr(ADDR_REF_CTL, 32'h00, 4'hF);
    rd_chk("ready_when_off", ADDR_REF_CTL, 32'h40);
    // Unmasked completions on several channels and references
    bus_wr(ADDR_IRQ_MASK, 32'h1, 4'hF);
    for (int k = 0; k < 3; k++) begin
      convert(chs[k], exts[k]);
      wait_for(0, 1'b1);
      chk("irq", 32'h1, {31'h0, irq});
      chk("wake_idle", 32'h0, {31'h0, wake_req});
      res_chk(chs[k], exts[k]);
      rd_chk("status", ADDR_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq_cleared", 32'h0, {31'h0, irq});
    end
    // Completion wakes the core from sleep
    sleep_mode <= 1'b1;
    convert(3'h3, 1'b1);
    wait_for(1, 1'b1);
    chk("wake_req", 32'h1, {31'h0, wake_req});
    rd_chk("status_sleep", ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("wake_cleared", 32'h0, {31'h0, wake_req});
    sleep_mode <= 1'b0;
    // Masked; second start while busy is ignored
    bus_wr(ADDR_IRQ_MASK, 32'h0, 4'hF);
    convert(3'h2, 1'b0);
    bus_wr(ADDR_CONV_CTL, {27'h0, 1'b0, 3'h6, 1'b1}, 4'hF);
    for (int i = 0; i < 100; i++) begin
      bus_rd(ADDR_CONV_CTL, rd);
      if (rd[0] === 1'b0) break;
    end
    chk("busy_done", 32'h0, {31'h0, rd[0]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    res_chk(3'h2, 1'b0);
    rd_chk("status_sticky", ADDR_IRQ_STAT, 32'h1);
    rd_chk("status_clear", ADDR_IRQ_STAT, 32'h0);
    close_out();
  end
endmodule : rac_top_tb_top
